/* sqt_pkg.sv */
// package: constants, states and carrier types of the memory boundary-scan port
package sqt_pkg;

	// instruction register width and codes
	localparam int          IR_W          = 3;
	localparam logic [2:0]  INS_EXT_TEST  = 3'h0;
	localparam logic [2:0]  INS_IDENT     = 3'h1;
	localparam logic [2:0]  INS_SAMPLE_Z  = 3'h2;
	localparam logic [2:0]  INS_PRIV_A    = 3'h3;
	localparam logic [2:0]  INS_SAMPLE_PL = 3'h4;
	localparam logic [2:0]  INS_PRIV_B    = 3'h5;
	localparam logic [2:0]  INS_PRIV_C    = 3'h6;
	localparam logic [2:0]  INS_BYPASS    = 3'h7;

	// capture pattern for the instruction shift stage (low two bits 01)
	localparam logic [2:0]  IR_CAPTURE    = 3'h1;

	// identification register layout
	localparam int          ID_W          = 32;
	localparam int          ID_MFR_LSB    = 1;
	localparam int          ID_MFR_W      = 11;
	localparam int          ID_MODEL_LSB  = 12;
	localparam int          ID_MODEL_W    = 20;
	localparam logic        ID_PRESENCE   = 1'b1;

	// synchroniser depth for inputs from the test-clock domain
	localparam int          SYNC_DEPTH    = 3;

	// tap controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET   = 16'h0001,
		ST_IDLE    = 16'h0002,
		ST_SEL_DR  = 16'h0004,
		ST_CAP_DR  = 16'h0008,
		ST_SH_DR   = 16'h0010,
		ST_EX1_DR  = 16'h0020,
		ST_PAU_DR  = 16'h0040,
		ST_EX2_DR  = 16'h0080,
		ST_UPD_DR  = 16'h0100,
		ST_SEL_IR  = 16'h0200,
		ST_CAP_IR  = 16'h0400,
		ST_SH_IR   = 16'h0800,
		ST_EX1_IR  = 16'h1000,
		ST_PAU_IR  = 16'h2000,
		ST_EX2_IR  = 16'h4000,
		ST_UPD_IR  = 16'h8000
	} sqt_state_t;

	// test port pins as seen at the device
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} sqt_pins_t;

	// reset value of the filtered pins: undriven pins read as one
	localparam sqt_pins_t   PINS_IDLE     = '{tck: 1'b1, tms: 1'b1, tdi: 1'b1};

endpackage

/* sqt_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
module sqt_sync #(
	parameter int               W     = 3,
	parameter logic [W-1:0]     INIT  = '1
) (
	// clock and reset
	input  wire logic           core_clk_i,
	input  wire logic           arst_n_i,
	// raw and filtered levels
	input  wire logic [W-1:0]   raw_i,
	output logic      [W-1:0]   level_o
);

	logic [W-1:0] st1_reg;
	logic [W-1:0] st2_reg;
	logic [W-1:0] st3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;

	////////////////////////////////////////////////////////////////////////////
	// a bit moves only when stages two and three agree; stage one feeds stage two only
	assign level_next = (st2_reg & ~(st2_reg ^ st3_reg)) | (level_reg & (st2_reg ^ st3_reg));

	// chain of flops, reset to the idle pin level
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st1_reg   <= INIT;
			st2_reg   <= INIT;
			st3_reg   <= INIT;
			level_reg <= INIT;
		end
		else
		begin
			st1_reg   <= raw_i;
			st2_reg   <= st1_reg;
			st3_reg   <= st2_reg;
			level_reg <= level_next;
		end
	end

	assign level_o = level_reg;

endmodule // sqt_sync

/* sqt_tap.sv */
// boundary-scan test access port of the memory: controller, instruction and data registers
//
// Function
// - capture-ir loads 01 into the two lowest instruction bits
// - shift-ir shifts instruction in from data input, old contents out
// - new instruction becomes active only at update-ir
// - code 000 puts boundary register in the serial path (external test)
// - code 010 captures pads, shifts boundary register, floats memory outputs
// - code 100 copies input and io pad levels into boundary register at capture-dr
// - code 111 puts the one-bit bypass register in the serial path
// - code 001 loads identification constant at capture-dr and shifts it
// - identification instruction active after power-up and test-logic-reset
// - unpinned boundary cells capture their fixed default
// - sample/preload connects boundary register during shift-dr
// - external test never isolates the memory core from its inputs
// - external test drives boundary contents onto outputs on falling clock in update-ir
// - external test captures pads plus unpinned defaults at rising clock in capture-dr
// - mode select high for five rising clocks reaches test-logic-reset
// - inputs sampled on rising test clock, data output changes on falling
// - instruction register is three bits wide
// - undriven mode select or data input reads as one
module sqt_tap #(
	parameter int                     BSR_W      = 8,
	parameter logic [BSR_W-1:0]       PINNED     = 8'h3f,
	parameter logic [BSR_W-1:0]       BSR_DEFLT  = 8'hc0,
	// arbitrary neutral identity values
	parameter logic [sqt_pkg::ID_MFR_W-1:0]   ID_MFR   = 11'h2a5,
	parameter logic [sqt_pkg::ID_MODEL_W-1:0] ID_MODEL = 20'h00001
) (
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 arst_n_i,
	// test port pins
	input  wire sqt_pkg::sqt_pins_t   jtag_i,
	output logic                      tdo_o,
	output logic                      tdo_oe_n_o,
	// memory pad ring
	input  wire logic [BSR_W-1:0]     pad_i,
	output logic      [BSR_W-1:0]     scan_out_o,
	output logic                      scan_drive_o,
	output logic                      out_hiz_o
);

	sqt_pkg::sqt_pins_t   pins;
	sqt_pkg::sqt_state_t  state_reg;
	sqt_pkg::sqt_state_t  state_next;
	logic                 tck_prev_reg;
	logic [2:0]           ir_sh_reg;
	logic [2:0]           ir_reg;
	logic [BSR_W-1:0]     bsr_reg;
	logic [BSR_W-1:0]     bsr_upd_reg;
	logic [sqt_pkg::ID_W-1:0] id_reg;
	logic                 byp_reg;
	logic                 tdo_reg;
	logic                 tdo_oe_n_reg;

	////////////////////////////////////////////////////////////////////////////
	// pins cross into the core clock; idle level is one, as with the pad pull-ups
	sqt_sync #(
		.W     (3),
		.INIT  (sqt_pkg::PINS_IDLE)
	) u_sync (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.raw_i      (jtag_i),
		.level_o    (pins)
	);

	////////////////////////////////////////////////////////////////////////////
	// test clock edges and instruction decode
	wire tck_rise  = pins.tck & ~tck_prev_reg;
	wire tck_fall  = ~pins.tck & tck_prev_reg;
	wire sel_bsr   = (ir_reg == sqt_pkg::INS_EXT_TEST) | (ir_reg == sqt_pkg::INS_SAMPLE_Z)
	               | (ir_reg == sqt_pkg::INS_SAMPLE_PL);
	wire sel_id    = (ir_reg == sqt_pkg::INS_IDENT);
	// every other code, the private ones included, falls to bypass
	wire sel_byp   = ~sel_bsr & ~sel_id;
	// unpinned cells take their default instead of a pad level
	wire [BSR_W-1:0] bsr_cap = (pad_i & PINNED) | (BSR_DEFLT & ~PINNED);
	wire [sqt_pkg::ID_W-1:0] id_word =
		{ID_MODEL, ID_MFR, sqt_pkg::ID_PRESENCE};
	wire dr_lsb    = sel_bsr ? bsr_reg[0] : (sel_id ? id_reg[0] : byp_reg);
	wire ir_is_ext = (ir_sh_reg == sqt_pkg::INS_EXT_TEST);

	////////////////////////////////////////////////////////////////////////////
	// controller next state on mode select; five highs from anywhere reach reset
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			sqt_pkg::ST_RESET:  state_next = pins.tms ? sqt_pkg::ST_RESET  : sqt_pkg::ST_IDLE;
			sqt_pkg::ST_IDLE:   state_next = pins.tms ? sqt_pkg::ST_SEL_DR : sqt_pkg::ST_IDLE;
			sqt_pkg::ST_SEL_DR: state_next = pins.tms ? sqt_pkg::ST_SEL_IR : sqt_pkg::ST_CAP_DR;
			sqt_pkg::ST_CAP_DR: state_next = pins.tms ? sqt_pkg::ST_EX1_DR : sqt_pkg::ST_SH_DR;
			sqt_pkg::ST_SH_DR:  state_next = pins.tms ? sqt_pkg::ST_EX1_DR : sqt_pkg::ST_SH_DR;
			sqt_pkg::ST_EX1_DR: state_next = pins.tms ? sqt_pkg::ST_UPD_DR : sqt_pkg::ST_PAU_DR;
			sqt_pkg::ST_PAU_DR: state_next = pins.tms ? sqt_pkg::ST_EX2_DR : sqt_pkg::ST_PAU_DR;
			sqt_pkg::ST_EX2_DR: state_next = pins.tms ? sqt_pkg::ST_UPD_DR : sqt_pkg::ST_SH_DR;
			sqt_pkg::ST_UPD_DR: state_next = pins.tms ? sqt_pkg::ST_SEL_DR : sqt_pkg::ST_IDLE;
			sqt_pkg::ST_SEL_IR: state_next = pins.tms ? sqt_pkg::ST_RESET  : sqt_pkg::ST_CAP_IR;
			sqt_pkg::ST_CAP_IR: state_next = pins.tms ? sqt_pkg::ST_EX1_IR : sqt_pkg::ST_SH_IR;
			sqt_pkg::ST_SH_IR:  state_next = pins.tms ? sqt_pkg::ST_EX1_IR : sqt_pkg::ST_SH_IR;
			sqt_pkg::ST_EX1_IR: state_next = pins.tms ? sqt_pkg::ST_UPD_IR : sqt_pkg::ST_PAU_IR;
			sqt_pkg::ST_PAU_IR: state_next = pins.tms ? sqt_pkg::ST_EX2_IR : sqt_pkg::ST_PAU_IR;
			sqt_pkg::ST_EX2_IR: state_next = pins.tms ? sqt_pkg::ST_UPD_IR : sqt_pkg::ST_SH_IR;
			sqt_pkg::ST_UPD_IR: state_next = pins.tms ? sqt_pkg::ST_SEL_DR : sqt_pkg::ST_IDLE;
			default:            state_next = sqt_pkg::ST_RESET;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// controller state, stepped on rising test clock; power-up lands in reset
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg    <= sqt_pkg::ST_RESET;
			tck_prev_reg <= 1'b1;
		end
		else
		begin
			tck_prev_reg <= pins.tck;
			if (tck_rise)
				state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// instruction shift stage and active instruction; the active code only moves on a
	// falling test clock, the reset in test-logic-reset too, so modes never move mid-cycle
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ir_sh_reg <= sqt_pkg::IR_CAPTURE;
			ir_reg    <= sqt_pkg::INS_IDENT;
		end
		else if (tck_rise)
		begin
			if (state_reg == sqt_pkg::ST_CAP_IR)
				ir_sh_reg <= sqt_pkg::IR_CAPTURE;
			if (state_reg == sqt_pkg::ST_SH_IR)
				ir_sh_reg <= {pins.tdi, ir_sh_reg[2:1]};
		end
		else if (tck_fall)
		begin
			if (state_reg == sqt_pkg::ST_RESET)
				ir_reg <= sqt_pkg::INS_IDENT;
			if (state_reg == sqt_pkg::ST_UPD_IR)
				ir_reg <= ir_sh_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data registers: capture and shift on rising test clock for the selected one
	// pad capture is only repeatable if the memory inputs are held still meanwhile
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bsr_reg <= BSR_DEFLT;
			id_reg  <= '0;
			byp_reg <= 1'b0;
		end
		else if (tck_rise)
		begin
			if (state_reg == sqt_pkg::ST_CAP_DR)
			begin
				if (sel_bsr)
					bsr_reg <= bsr_cap;
				if (sel_id)
					id_reg <= id_word;
				if (sel_byp)
					byp_reg <= 1'b0;
			end
			if (state_reg == sqt_pkg::ST_SH_DR)
			begin
				if (sel_bsr)
					bsr_reg <= {pins.tdi, bsr_reg[BSR_W-1:1]};
				if (sel_id)
					id_reg <= {pins.tdi, id_reg[sqt_pkg::ID_W-1:1]};
				if (sel_byp)
					byp_reg <= pins.tdi;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// parallel output stage: loaded on the falling clock in update-ir when external
	// test is going active, and in update-dr while external test is active
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			bsr_upd_reg <= BSR_DEFLT;
		else if (tck_fall && state_reg == sqt_pkg::ST_UPD_IR && ir_is_ext)
			bsr_upd_reg <= bsr_reg;
		else if (tck_fall && state_reg == sqt_pkg::ST_UPD_DR
		         && ir_reg == sqt_pkg::INS_EXT_TEST)
			bsr_upd_reg <= bsr_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// serial output changes on the falling test clock only, driven in shift states
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tdo_reg      <= 1'b1;
			tdo_oe_n_reg <= 1'b1;
		end
		else if (tck_fall)
		begin
			if (state_reg == sqt_pkg::ST_SH_IR)
			begin
				tdo_reg      <= ir_sh_reg[0];
				tdo_oe_n_reg <= 1'b0;
			end
			else if (state_reg == sqt_pkg::ST_SH_DR)
			begin
				tdo_reg      <= dr_lsb;
				tdo_oe_n_reg <= 1'b0;
			end
			else
				tdo_oe_n_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; no core isolation output exists, the core keeps seeing its pins
	assign tdo_o        = tdo_reg;
	assign tdo_oe_n_o   = tdo_oe_n_reg;
	assign scan_out_o   = bsr_upd_reg;
	assign scan_drive_o = (ir_reg == sqt_pkg::INS_EXT_TEST);
	assign out_hiz_o    = (ir_reg == sqt_pkg::INS_SAMPLE_Z);

endmodule // sqt_tap

/* sqt_tap_sva.sv */
// port assertions of the memory boundary-scan port, bound into the sqt_tap module
module sqt_tap_sva #(
	parameter int               BSR_W     = 8,
	parameter logic [BSR_W-1:0] BSR_DEFLT = '1
) (
	// clock, reset and test pins
	input  wire logic               core_clk_i,
	input  wire logic               arst_n_i,
	input  wire sqt_pkg::sqt_pins_t jtag_i,
	input  wire logic               tdo_o,
	input  wire logic               tdo_oe_n_o,
	// pad ring
	input  wire logic [BSR_W-1:0]   pad_i,
	input  wire logic [BSR_W-1:0]   scan_out_o,
	input  wire logic               scan_drive_o,
	input  wire logic               out_hiz_o
);
	logic [2:0] tck_hist;
	logic [2:0] ones;
	logic       fell_seen;
	////////////////////////////////////////////////////////////////////////////////
	// pin history; tms-high rises are counted so a walk to reset is visible
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tck_hist <= 3'h7;
			ones     <= 3'h0;
		end
		else
		begin
			tck_hist <= {tck_hist[1:0], jtag_i.tck};
			if (jtag_i.tck && !tck_hist[0])
				ones <= jtag_i.tms ? ones + 3'(ones != 3'h7) : 3'h0;
		end
	end
	// outputs move only a few cycles after a seen fall, so a low level sits behind them
	assign fell_seen = !tck_hist[1] && !tck_hist[2];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_excl; !(scan_drive_o && out_hiz_o); endproperty
	a_excl: assert property (p_excl) else $error("drive and float together");
	property p_tdo_fall; $changed(tdo_o) |-> fell_seen; endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a fall");
	property p_oe_fall; $changed(tdo_oe_n_o) |-> fell_seen; endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved off a fall");
	property p_upd_fall; $changed(scan_out_o) |-> fell_seen ##[0:1] scan_drive_o; endproperty
	a_upd_fall: assert property (p_upd_fall) else $error("bad pad update");
	property p_ins_fall; $changed({scan_drive_o, out_hiz_o}) |-> fell_seen; endproperty
	a_ins_fall: assert property (p_ins_fall) else $error("mode moved off a fall");
	property p_hold_shift;
		!tdo_oe_n_o && !$past(tdo_oe_n_o) |-> $stable({scan_drive_o, out_hiz_o, scan_out_o});
	endproperty
	a_hold_shift: assert property (p_hold_shift) else $error("mode moved in shift");
	property p_rst;
		$rose(arst_n_i) |-> tdo_oe_n_o && tdo_o && !scan_drive_o && !out_hiz_o
			&& scan_out_o == BSR_DEFLT;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_tlr; ones >= 3'h6 |-> tdo_oe_n_o && !scan_drive_o && !out_hiz_o; endproperty
	a_tlr: assert property (p_tlr) else $error("no reset after tms ones");
endmodule // sqt_tap_sva

bind sqt_tap sqt_tap_sva #(.BSR_W(BSR_W), .BSR_DEFLT(BSR_DEFLT)) u_sva (
	.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .jtag_i(jtag_i), .tdo_o(tdo_o),
	.tdo_oe_n_o(tdo_oe_n_o), .pad_i(pad_i), .scan_out_o(scan_out_o),
	.scan_drive_o(scan_drive_o), .out_hiz_o(out_hiz_o));

/* sqt_ctl_model.sv */
// board scan controller model: drives the test pins, reads tdo late in each clock
module sqt_ctl_model (
	// clock
	input  wire logic          core_clk_i,
	// test port
	output sqt_pkg::sqt_pins_t jtag_o,
	input  wire logic          tdo_i,
	input  wire logic          tdo_oe_n_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic q;
	logic qoe;
	// pins idle high, as the pull-ups leave them; tck stands still between steps
	initial jtag_o = sqt_pkg::PINS_IDLE;
	////////////////////////////////////////////////////////////////////////////////
	// one 800 ns test clock; tms/tdi change with the fall, tdo read just before the next
	task automatic step(input logic m, input logic d);
	begin
		jtag_o <= '{tck: 1'b0, tms: m, tdi: d};
		repeat (4) @(posedge core_clk_i);
		jtag_o.tck <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		q = tdo_i;
		qoe = tdo_oe_n_i;
		@(posedge core_clk_i);
	end
	endtask
	// tms sequence, first bit lowest; five ones reach reset from anywhere
	task automatic walk(input logic [7:0] s, input int n);
	begin
		for (int i = 0; i < n; i++)
			step(s[i], 1'b1);
	end
	endtask
	// serial shift of n bits, lowest first, leaving in exit1
	task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout,
		output logic oe_bad);
	begin
		dout = '0;
		oe_bad = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i]);
			dout[i] = q;
			oe_bad = oe_bad | qoe;
		end
	end
	endtask
endmodule // sqt_ctl_model

/* sqt_tap_bench.sv */
// self-checking bench of the memory boundary-scan port
module sqt_tap_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0]  PIN   = 8'h3f;
	localparam logic [7:0]  DEF   = 8'hc0;
	localparam logic [10:0] MFR   = 11'h155;   // arbitrary maker value
	localparam logic [19:0] MODEL = 20'h0abcd; // arbitrary model value
	localparam logic [31:0] ID    = {MODEL, MFR, 1'b1};
	localparam logic [11:0] BYP   = 12'heee;   // codes 6, 5, 3, 7 from the low end
	logic               core_clk_i;
	logic               arst_n_i;
	sqt_pkg::sqt_pins_t jtag;
	logic               tdo;
	logic               tdo_oe_n;
	logic [7:0]         pad_i;
	logic [7:0]         scan_out;
	logic               drive;
	logic               hiz;
	logic [31:0]        got;
	logic               oe_bad;
	int                 n_fail;
	int                 comparisons;
	sqt_tap #(.BSR_W(8), .PINNED(PIN), .BSR_DEFLT(DEF), .ID_MFR(MFR), .ID_MODEL(MODEL)) dut (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .jtag_i(jtag), .tdo_o(tdo),
		.tdo_oe_n_o(tdo_oe_n), .pad_i(pad_i), .scan_out_o(scan_out), .scan_drive_o(drive),
		.out_hiz_o(hiz));
	sqt_ctl_model ctl (.core_clk_i(core_clk_i), .jtag_o(jtag), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
	begin
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	end
	endtask
	// instruction shift left in exit1, so the old mode can be looked at before update
	task automatic load_ir(input logic [2:0] c);
	begin
		ctl.walk(8'h03, 4);
		ctl.scan({29'h0, c}, 3, got, oe_bad);
	end
	endtask
	// data shift from idle back to idle
	task automatic load_dr(input logic [31:0] d, input int n);
	begin
		ctl.walk(8'h01, 3);
		ctl.scan(d, n, got, oe_bad);
		ctl.walk(8'h01, 2);
	end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_ident;
	begin
		chk({21'h0, drive, hiz, tdo_oe_n, scan_out}, {21'h0, 3'h1, DEF});
		ctl.walk(8'h00, 1);
		load_dr(32'h0, 32);
		chk(got, ID);
		chk(32'(oe_bad), 32'h0);
	end
	endtask
	task automatic t_bypass;
	begin
		for (int i = 0; i < 4; i++)
		begin
			load_ir(BYP[3*i +: 3]);
			chk(got, 32'h1);
			ctl.walk(8'h01, 2);
			load_dr(32'ha5, 8);
			chk(got, 32'h4a);
			chk({30'h0, drive, hiz}, 32'h0);
		end
	end
	endtask
	task automatic t_preload;
	begin
		pad_i <= 8'h5a; // held steady across the capture
		load_ir(sqt_pkg::INS_SAMPLE_PL);
		ctl.walk(8'h01, 2);
		load_dr(32'h3c, 8);
		chk(got, 32'hda);
		chk({24'h0, scan_out}, {24'h0, DEF});
	end
	endtask
	task automatic t_extest;
	begin
		pad_i <= 8'h21;
		load_ir(sqt_pkg::INS_EXT_TEST);
		chk(32'(drive), 32'h0);
		ctl.walk(8'h01, 2);
		chk({23'h0, drive, scan_out}, {23'h0, 1'b1, 8'h3c});
		load_dr(32'h99, 8);
		chk(got, 32'he1);
		chk({24'h0, scan_out}, 32'h99);
	end
	endtask
	task automatic t_samplez;
	begin
		pad_i <= 8'h0f;
		load_ir(sqt_pkg::INS_SAMPLE_Z);
		ctl.walk(8'h01, 2);
		chk({30'h0, drive, hiz}, 32'h1);
		load_dr(32'h0, 8);
		chk(got, 32'hcf);
	end
	endtask
	// reach reset from inside a data shift, with the float mode active
	task automatic t_reset;
	begin
		ctl.walk(8'h01, 3);
		ctl.walk(8'h3f, 6);
		chk({29'h0, drive, hiz, tdo_oe_n}, 32'h1);
		ctl.walk(8'h00, 1);
		load_dr(32'h0, 32);
		chk(got, ID);
	end
	endtask
	task automatic stop_test;
	begin
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		arst_n_i = 1'b0;
		pad_i = 8'h00;
		n_fail = 0;
		comparisons = 0;
		repeat (3) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		t_ident();
		t_bypass();
		t_preload();
		t_extest();
		t_samplez();
		t_reset();
		stop_test();
	end
endmodule // sqt_tap_bench
